// >>> core/scs_top.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE_01 - RC mode drives oscillator clock divided by four on the secondary pin
// RULE_02 - RC with I/O mode frees the secondary pin as port A bit six
// RULE_03 - External clock mode drives input clock divided by four on secondary pin
// RULE_04 - External clock with I/O mode frees the secondary pin as port A bit six
// RULE_05 - External clock modes skip start-up delay after reset and wake
// RULE_06 - Outside party supplies a running clock on the primary input in EC modes
// RULE_07 - Crystal modes also run from an external clock on the primary input
// RULE_08 - PLL option multiplies the incoming clock by four
// RULE_09 - PLL only in high-speed mode; otherwise clock comes straight from primary
// RULE_10 - PLL is one code of the fixed three-bit mode field
// RULE_11 - Lock timer holds off execution until the PLL has locked
// RULE_12 - Switching to auxiliary clock needs the switch-enable bit programmed low
// RULE_13 - Erased configuration keeps switching off, main oscillator stays
// RULE_14 - Auxiliary clock usable only when its oscillator is enabled
// RULE_15 - Eight oscillator modes chosen by a three-bit field
// RULE_16 - Clock select one picks auxiliary, zero main; reset clears it
// RULE_17 - With auxiliary oscillator off, clock select writes are forced to zero
// RULE_18 - Mode field encoding is defined by this implementation
module scs_top
  import scs_pkg::*;
#(
  parameter int unsigned LOCK_CYC = PLL_LOCK_CYC // PLL lock wait in cycles
) (
  input wire logic hclk, // Bus and sampling clock
  input wire logic hresetn, // Async reset, low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write strobe
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic [2:0] osc_mode_select, // Programmed mode
  input wire logic clock_switch_enable_n, // Programmed switch enable
  input wire logic primary_clock_in, // Main oscillator pin
  input wire logic aux_clock_in, // Auxiliary oscillator
  input wire logic sleep_req, // Enter sleep
  input wire logic wake_req, // Leave sleep
  input wire logic secondary_osc_i, // Secondary pin level
  output logic secondary_osc_o, // Secondary pin data
  output logic secondary_osc_oe_n, // Secondary pin drive, low
  output logic sys_clk_tick, // System clock pulse
  output logic cpu_run, // Execution allowed
  output logic clock_on_aux // Running from auxiliary
);

  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    scs_state_t st;
    scs_mode_t mode;
    logic sw_n;
    logic [CTRL_W-1:0] ctrl;
    logic [2:0] pri_s;
    logic [2:0] aux_s;
    logic [2:0] sec_s;
    logic pri_l;
    logic aux_l;
    logic sec_l;
    logic pri_rise;
    logic [1:0] div;
    logic [OST_W-1:0] ost;
    logic wr_pend;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic tick;
    logic run;
    logic on_aux;
    logic so;
    logic soe_n;
  } scs_regs_t;

  // Erased switch bit reads as one until configuration is caught
  localparam scs_regs_t RST = '{
    st: ST_HOLD,
    mode: M_LOW_POWER,
    sw_n: 1'b1,
    ctrl: CTRL_RST,
    ready: 1'b1,
    soe_n: 1'b1,
    default: '0
  };

  scs_regs_t q;
  scs_regs_t d;
  scs_mode_t mode_in;
  logic pri_rise;
  logic aux_rise;
  logic acc;
  logic sw_ok;
  logic pll_en;
  logic pll_tick;
  logic pll_locked;
  logic src_tick;
  logic [STAT_W-1:0] stat;

  // Change counts once second and third stages agree
  function automatic logic sync_rise(logic [2:0] s, logic l);
    return (s[SYNC_B] == s[SYNC_C]) && s[SYNC_C] && !l;
  endfunction

  function automatic logic sync_lvl(logic [2:0] s, logic l);
    return (s[SYNC_B] == s[SYNC_C]) ? s[SYNC_C] : l;
  endfunction

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    d = q;
    mode_in = scs_mode_t'(osc_mode_select); // [RULE_15] [RULE_18]
    d.pri_s = {q.pri_s[1:0], primary_clock_in};
    d.aux_s = {q.aux_s[1:0], aux_clock_in};
    d.sec_s = {q.sec_s[1:0], secondary_osc_i};
    pri_rise = sync_rise(q.pri_s, q.pri_l);
    aux_rise = sync_rise(q.aux_s, q.aux_l);
    d.pri_l = sync_lvl(q.pri_s, q.pri_l);
    d.aux_l = sync_lvl(q.aux_s, q.aux_l);
    d.sec_l = sync_lvl(q.sec_s, q.sec_l);
    d.pri_rise = pri_rise;
    if (pri_rise) begin
      d.div = q.div + 1'b1;
    end

    // Start-up sequencing
    case (q.st)
      ST_HOLD: begin
        // Mode and switch bit are fixed; caught once after release
        d.mode = mode_in; // [RULE_10]
        d.sw_n = clock_switch_enable_n; // [RULE_13]
        d.ost = '0;
        if (scs_is_crystal(mode_in)) begin
          d.st = ST_OST; // [RULE_07]
        end else begin
          d.st = ST_RUN; // [RULE_05]
        end
      end
      ST_OST: begin
        // Crystal or external clock alike: only edges are counted
        if (pri_rise) begin // [RULE_07]
          if (q.ost == OST_LAST) begin
            d.st = (q.mode == M_HIGH_SPEED_PLL) ? ST_LOCK : ST_RUN;
          end else begin
            d.ost = q.ost + 1'b1;
          end
        end
      end
      ST_LOCK: begin
        if (pll_locked) begin
          d.st = ST_RUN; // [RULE_11]
        end
      end
      ST_RUN: begin
        if (sleep_req) begin
          d.st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_req) begin
          d.ost = '0;
          d.st = scs_is_crystal(q.mode) ? ST_OST : ST_RUN; // [RULE_05]
        end
      end
      default: begin
        d.st = ST_HOLD;
      end
    endcase
    d.run = (d.st == ST_RUN); // [RULE_11]

    // Register writes land in the data phase
    if (q.wr_pend) begin
      d.ctrl = hwdata[CTRL_W-1:0];
    end
    // Select is only kept while both enables allow it
    sw_ok = !q.sw_n && d.ctrl[CTRL_AUXEN]; // [RULE_12] [RULE_14]
    d.ctrl[CTRL_SEL] = d.ctrl[CTRL_SEL] && sw_ok; // [RULE_17]
    d.on_aux = q.ctrl[CTRL_SEL]; // [RULE_16]

    // System clock source
    if (q.on_aux) begin
      src_tick = aux_rise; // [RULE_16]
    end else if (q.mode == M_HIGH_SPEED_PLL) begin
      src_tick = pll_tick; // [RULE_08]
    end else begin
      src_tick = pri_rise; // [RULE_09]
    end
    d.tick = q.run && src_tick;

    // Secondary pin
    if (scs_div_out(q.mode)) begin
      // Held low while asleep, matching the stopped oscillator
      d.soe_n = 1'b0;
      d.so = (q.st == ST_RUN) ? q.div[DIV_BIT] : 1'b0; // [RULE_01] [RULE_03]
    end else if (scs_gpio(q.mode)) begin
      d.soe_n = !q.ctrl[CTRL_GPOE]; // [RULE_02] [RULE_04]
      d.so = q.ctrl[CTRL_GPO];
    end else begin
      d.soe_n = 1'b1;
      d.so = 1'b0;
    end

    // Bus slave, no wait states
    acc = hsel && hready && htrans[1];
    d.wr_pend = acc && hwrite && (haddr[ADDR_W-1:0] == ADDR_CTRL);
    d.ready = 1'b1;
    d.resp = 1'b0;
    stat = '0;
    stat[STAT_MODE +: 3] = d.mode;
    stat[STAT_SWEN] = !d.sw_n;
    stat[STAT_RUN] = d.run;
    stat[STAT_LOCK] = pll_locked;
    stat[STAT_AUX] = d.on_aux;
    stat[STAT_PIN] = d.sec_l;
    // Read from the next state so a write just before is seen
    d.rdata = '0;
    if (acc && !hwrite) begin
      if (haddr[ADDR_W-1:0] == ADDR_CTRL) begin
        d.rdata = 32'(d.ctrl);
      end else if (haddr[ADDR_W-1:0] == ADDR_STAT) begin
        d.rdata = 32'(stat);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ************************************************
  // PLL model
  // ************************************************
  // Off outside high-speed PLL mode; lock time runs after start-up
  assign pll_en = (q.mode == M_HIGH_SPEED_PLL) && (q.st == ST_LOCK || q.st == ST_RUN); // [RULE_09]

  scs_pll #(
    .LOCK_CYC(LOCK_CYC)
  ) u_pll (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(pll_en),
    .ref_rise(q.pri_rise),
    .tick(pll_tick),
    .locked(pll_locked)
  );

  // ************************************************
  // Outputs
  // ************************************************
  assign hreadyout = q.ready;
  assign hresp = q.resp;
  assign hrdata = q.rdata;
  assign secondary_osc_o = q.so;
  assign secondary_osc_oe_n = q.soe_n;
  assign sys_clk_tick = q.tick;
  assign cpu_run = q.run;
  assign clock_on_aux = q.on_aux;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_lock_done;
    q.st == ST_LOCK && pll_locked;
  endsequence

  sequence s_running;
    q.st == ST_RUN && cpu_run;
  endsequence

  sequence s_ext_start;
    q.st == ST_HOLD && scs_is_ext(mode_in);
  endsequence

  AST_RESCAP_DIV4: assert property ((q.mode == M_RES_CAP && q.st == ST_RUN) |=> // [RULE_01]
    (!secondary_osc_oe_n && secondary_osc_o == $past(q.div[DIV_BIT])))
    else $error("RC mode secondary pin not f/4");

  AST_EXTCLK_DIV4: assert property ((q.mode == M_EXT_CLK && q.st == ST_RUN) |=> // [RULE_03]
    (!secondary_osc_oe_n && secondary_osc_o == $past(q.div[DIV_BIT])))
    else $error("EC mode secondary pin not f/4");

  AST_RESCAP_IO_PORT: assert property ((q.mode == M_RES_CAP_IO) |=> // [RULE_02]
    (secondary_osc_oe_n == !$past(q.ctrl[CTRL_GPOE]) && secondary_osc_o == $past(q.ctrl[CTRL_GPO])))
    else $error("RESISTOR_CAP_GPIO_MODE secondary pin not port bit");

  AST_EXTCLK_IO_PORT: assert property ((q.mode == M_EXT_CLK_IO) |=> // [RULE_04]
    (secondary_osc_oe_n == !$past(q.ctrl[CTRL_GPOE]) && secondary_osc_o == $past(q.ctrl[CTRL_GPO])))
    else $error("EXT_CLOCK_GPIO_MODE secondary pin not port bit");

  AST_EXT_NO_OST: assert property (s_ext_start |=> s_running) // [RULE_05]
    else $error("external clock start delayed");

  AST_EXT_WAKE: assert property ((q.st == ST_SLEEP && wake_req && scs_is_ext(q.mode)) |=> s_running) // [RULE_05]
    else $error("external clock wake delayed");

  AST_XTAL_OST: assert property ((q.st == ST_HOLD && scs_is_crystal(mode_in)) |=> // [RULE_07]
    (q.st == ST_OST && !cpu_run))
    else $error("crystal mode skipped start-up");

  AST_PLL_HIGH_SPEED_ONLY: assert property ((q.mode != M_HIGH_SPEED_PLL) |-> (!pll_en && !pll_locked)) // [RULE_09]
    else $error("PLL on outside high-speed mode");

  AST_DIRECT_CLK: assert property ((q.run && !q.on_aux && q.mode != M_HIGH_SPEED_PLL) |=> // [RULE_09]
    (sys_clk_tick == $past(pri_rise)))
    else $error("system clock not from primary");

  AST_LOCK_HOLDOFF: assert property ((q.st == ST_LOCK && !pll_locked) |=> !cpu_run) // [RULE_11]
    else $error("execution before PLL lock");

  AST_LOCK_RUN: assert property (s_lock_done |=> s_running) // [RULE_11]
    else $error("no run after PLL lock");

  AST_SWITCH_GATE: assert property ((q.sw_n || !q.ctrl[CTRL_AUXEN]) |-> !q.ctrl[CTRL_SEL]) // [RULE_12]
    else $error("clock select set while not allowed");

  AST_ERASED_MAIN: assert property (q.sw_n |=> !clock_on_aux) // [RULE_13]
    else $error("switched while switching disabled");

  AST_AUX_FORCE: assert property ((q.wr_pend && !hwdata[CTRL_AUXEN]) |=> !q.ctrl[CTRL_SEL]) // [RULE_17]
    else $error("select write not forced clear");

  AST_AUX_FOLLOW: assert property (clock_on_aux == $past(q.ctrl[CTRL_SEL])) // [RULE_16]
    else $error("clock source not following select");

  AST_AUX_TICK: assert property ((q.run && q.on_aux) |=> (sys_clk_tick == $past(aux_rise))) // [RULE_14]
    else $error("auxiliary clock not used");

endmodule
`default_nettype wire

// >>> core/scs_pkg.sv
package scs_pkg;

  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int PLL_LOCK_US = 2000;
  localparam int NS_PER_US = 1000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int OST_W = 11;
  localparam logic [OST_W-1:0] OST_LAST = 11'h3FF;
  localparam logic [1:0] PLL_SUB_LAST = 2'h3;
  localparam int QUARTER_SHIFT = 2;
  localparam int DIV_BIT = 1;
  localparam int SYNC_B = 1;
  localparam int SYNC_C = 2;

  // ************************************************
  // Register map
  // ************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
  localparam int CTRL_SEL = 0;
  localparam int CTRL_AUXEN = 1;
  localparam int CTRL_GPO = 2;
  localparam int CTRL_GPOE = 3;
  localparam int CTRL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam int STAT_MODE = 0;
  localparam int STAT_SWEN = 3;
  localparam int STAT_RUN = 4;
  localparam int STAT_LOCK = 5;
  localparam int STAT_AUX = 6;
  localparam int STAT_PIN = 7;
  localparam int STAT_W = 8;

  // ************************************************
  // Modes and states
  // ************************************************
  typedef enum logic [2:0] {
    M_LOW_POWER = 3'h0,
    M_CRYSTAL = 3'h1,
    M_HIGH_SPEED = 3'h2,
    M_HIGH_SPEED_PLL = 3'h3,
    M_RES_CAP = 3'h4,
    M_RES_CAP_IO = 3'h5,
    M_EXT_CLK = 3'h6,
    M_EXT_CLK_IO = 3'h7
  } scs_mode_t;

  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_OST = 5'h02,
    ST_LOCK = 5'h04,
    ST_RUN = 5'h08,
    ST_SLEEP = 5'h10
  } scs_state_t;

  function automatic logic scs_is_crystal(scs_mode_t m);
    return m inside {M_LOW_POWER, M_CRYSTAL, M_HIGH_SPEED, M_HIGH_SPEED_PLL};
  endfunction

  function automatic logic scs_is_ext(scs_mode_t m);
    return m inside {M_EXT_CLK, M_EXT_CLK_IO};
  endfunction

  function automatic logic scs_div_out(scs_mode_t m);
    return m inside {M_RES_CAP, M_EXT_CLK};
  endfunction

  function automatic logic scs_gpio(scs_mode_t m);
    return m inside {M_RES_CAP_IO, M_EXT_CLK_IO};
  endfunction

endpackage

// >>> core/scs_pll.sv
`timescale 1ns/100ps
`default_nettype none
module scs_pll
  import scs_pkg::*;
#(
  parameter int unsigned LOCK_CYC = PLL_LOCK_CYC
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, low
  input wire logic enable, // Loop running
  input wire logic ref_rise, // Reference edge pulse
  output logic tick, // Multiplied clock pulse
  output logic locked // Lock timer expired
);

  localparam logic [CNT_W-1:0] LOCK_END = CNT_W'(LOCK_CYC - 1);

  typedef struct packed {
    logic [CNT_W-1:0] phase;
    logic [CNT_W-1:0] quarter;
    logic [CNT_W-1:0] qcnt;
    logic [1:0] sub;
    logic [CNT_W-1:0] lock_cnt;
    logic tick;
    logic locked;
  } scs_pll_t;

  scs_pll_t q;
  scs_pll_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!enable) begin
      d.lock_cnt = '0;
      d.locked = 1'b0;
      d.sub = PLL_SUB_LAST;
    end else begin
      if (q.phase != '1) begin
        d.phase = q.phase + 1'b1;
      end
      if (q.lock_cnt == LOCK_END) begin
        d.locked = 1'b1; // [RULE_11]
      end else begin
        d.lock_cnt = q.lock_cnt + 1'b1;
      end
      if (ref_rise) begin
        // Period of the reference sets the spacing of four ticks
        d.quarter = q.phase >> QUARTER_SHIFT; // [RULE_08]
        d.qcnt = q.phase >> QUARTER_SHIFT;
        d.phase = '0;
        d.sub = '0;
        d.tick = 1'b1;
      end else if (q.sub != PLL_SUB_LAST) begin
        if (q.qcnt == '0) begin
          d.qcnt = q.quarter;
          d.sub = q.sub + 1'b1;
          d.tick = 1'b1; // [RULE_08]
        end else begin
          d.qcnt = q.qcnt - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
  assign locked = q.locked;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_PLL_REF_TICK: assert property ((enable && ref_rise) |=> (tick && q.sub == '0)) // [RULE_08]
    else $error("reference edge gave no tick");
  AST_PLL_UNLOCK: assert property (!enable |=> !locked) // [RULE_11]
    else $error("lock held while loop off");

endmodule
`default_nettype wire

// >>> verification/scs_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Far-side clock sources
// ****************************************
module scs_osc_model #(
  parameter int AUX_HALF = 6 // Auxiliary half period in cycles
) (
  input wire logic hclk, // Sampling clock
  input wire logic [7:0] pri_half, // Main half period in cycles
  output logic primary_clock_in, // Main source output
  output logic aux_clock_in // Auxiliary source output
);
  int pc = 0;
  int ac = 0;
  initial begin
    primary_clock_in = 1'b0;
    aux_clock_in = 1'b0;
  end
  // Both sources run free; the design has no oscillator of its own here
  always @(posedge hclk) begin
    pc = pc + 1;
    ac = ac + 1;
    if (pc >= int'(pri_half)) begin
      pc = 0;
      primary_clock_in <= ~primary_clock_in;
    end
    if (ac >= AUX_HALF) begin
      ac = 0;
      aux_clock_in <= ~aux_clock_in;
    end
  end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import scs_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic sleep_req = 1'b0;
  logic wake_req = 1'b0;
  logic swen_n = 1'b1;
  logic ext_lvl = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [2:0] mode = 3'h6;
  logic [7:0] half = 8'h02;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sec_o, sec_oe_n, tick, cpu_run, on_aux, pri, aux, sec_pin;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  // Pin resolved from both drivers so the design sees its own drive back
  assign sec_pin = sec_oe_n ? ext_lvl : sec_o;
  always #25 hclk = ~hclk;
  scs_osc_model i_scs_osc_model (.hclk(hclk), .pri_half(half), .primary_clock_in(pri), .aux_clock_in(aux));
  scs_top #(.LOCK_CYC(20)) i_scs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_mode_select(mode),
    .clock_switch_enable_n(swen_n), .primary_clock_in(pri), .aux_clock_in(aux), .sleep_req(sleep_req),
    .wake_req(wake_req), .secondary_osc_i(sec_pin), .secondary_osc_o(sec_o),
    .secondary_osc_oe_n(sec_oe_n), .sys_clk_tick(tick), .cpu_run(cpu_run), .clock_on_aux(on_aux));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  task automatic rst(input logic [2:0] m, input logic s);
    hresetn <= 1'b0;
    mode <= m;
    swen_n <= s;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  // Counts ticks and secondary toggles over n cycles
  task automatic win(input int n, output int t, output int g);
    logic p;
    t = 0;
    g = 0;
    p = sec_o;
    repeat (n) begin
      @(posedge hclk);
      t += int'(tick === 1'b1);
      g += int'(sec_o !== p);
      p = sec_o;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] r;
    for (int m = 0; m < 8; m++) begin
      rst(3'(m), m[0]);
      rd(ADDR_STAT, r);
      chk("stat_mode", 32'(m), {29'h0, r[2:0]});
      chk("stat_swen", {31'h0, ~m[0]}, {31'h0, r[3]});
      rd(ADDR_CTRL, r);
      chk("ctrl_reset", 32'h0, r);
      rd(8'h08, r);
      chk("unmapped", 32'h0, r);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
    end
    $display("test regs done");
  endtask
  task automatic t_div();
    int t, g;
    for (int i = 0; i < 2; i++) begin
      rst(i ? 3'h6 : 3'h4, 1'b1);
      chk("run_now", 32'h1, {31'h0, cpu_run});
      win(12, t, g);
      chk("div_oe_n", 32'h0, {31'h0, sec_oe_n});
      win(32, t, g);
      chk("div_ticks", 32'h8, t);
      chk("div_toggles", 32'h4, g);
    end
    $display("test divide done");
  endtask
  task automatic t_gpio();
    logic [31:0] r;
    for (int i = 0; i < 2; i++) begin
      rst(i ? 3'h7 : 3'h5, 1'b1);
      chk("gpio_oe_n_rst", 32'h1, {31'h0, sec_oe_n});
      wr(ADDR_CTRL, 32'hC);
      repeat (3) @(posedge hclk);
      chk("gpio_drive", 32'h1, {30'h0, sec_oe_n, sec_o});
      repeat (6) @(posedge hclk);
      rd(ADDR_STAT, r);
      chk("gpio_pin_hi", 32'h1, {31'h0, r[7]});
      wr(ADDR_CTRL, 32'h0);
      repeat (8) @(posedge hclk);
      rd(ADDR_STAT, r);
      chk("gpio_pin_lo", 32'h0, {31'h0, r[7]});
    end
    $display("test gpio done");
  endtask
  task automatic t_start(input logic [2:0] m, input logic [7:0] h, input int ost, input int ticks);
    int n, t, g;
    logic [31:0] r;
    half <= h;
    rst(m, 1'b1);
    n = 0;
    while (cpu_run !== 1'b1 && n < ost + 400) begin
      @(posedge hclk);
      n++;
    end
    chk("run_not_early", 32'h1, {31'h0, n >= ost});
    chk("run_seen", 32'h1, {31'h0, cpu_run});
    win(16 * h, t, g);
    win(16 * h, t, g);
    chk("start_ticks", 32'(ticks), t);
    rd(ADDR_STAT, r);
    chk("lock_bit", {31'h0, m == 3'h3}, {31'h0, r[5]});
    half <= 8'h02;
    $display("test start mode %0d done", m);
  endtask
  task automatic t_switch();
    logic [31:0] r;
    int t, g;
    rst(3'h6, 1'b0);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_CTRL, r);
    chk("sel_forced", 32'h0, {31'h0, r[0] | on_aux});
    wr(ADDR_CTRL, 32'h3);
    repeat (3) @(posedge hclk);
    chk("on_aux", 32'h1, {31'h0, on_aux});
    win(24, t, g);
    win(48, t, g);
    chk("aux_ticks", 32'h4, t);
    rst(3'h6, 1'b0);
    rd(ADDR_CTRL, r);
    chk("sel_cleared", 32'h0, {r[31:1], on_aux});
    rst(3'h7, 1'b1);
    wr(ADDR_CTRL, 32'h3);
    repeat (3) @(posedge hclk);
    rd(ADDR_CTRL, r);
    chk("erased_no_switch", 32'h0, {31'h0, r[0] | on_aux});
    $display("test switch done");
  endtask
  task automatic t_sleep();
    int t, g;
    rst(3'h6, 1'b1);
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("sleep_state", 32'h0, {30'h0, cpu_run, sec_o});
    win(16, t, g);
    chk("sleep_ticks", 32'h0, t);
    wake_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("wake_at_once", 32'h1, {31'h0, cpu_run});
    $display("test sleep done");
  endtask
  // ****************************************
  // Sequence and hang guard
  // ****************************************
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    t_regs();
    t_div();
    t_gpio();
    t_start(3'h1, 8'h02, 4092, 8);
    t_start(3'h2, 8'h02, 4092, 8);
    t_start(3'h3, 8'h04, 8204, 32);
    t_switch();
    t_sleep();
    final_report();
  end
endmodule
`default_nettype wire
